// ---- rtl/gp8_port.v ----
`timescale 1ns/1ps
`include "gp8_map.vh"

module gp8_port (
  input  wire        i_core_clk,              // Core clock, 40 MHz.
  input  wire        i_resetn,                // Power-on reset, async, active low.
  input  wire        i_link_fund_rst_n,       // Link fundamental reset, sync, active low.
  input  wire        i_global_reset_input_n,  // Global reset input, sync, active low.
  input  wire [7:0]  i_win_addr,              // Window register offset.
  input  wire        i_win_wr,                // Window write strobe.
  input  wire        i_win_rd,                // Window read strobe.
  input  wire [1:0]  i_win_be,                // Window byte enables.
  input  wire [15:0] i_win_wdata,             // Window write data.
  output wire [15:0] o_win_rdata,             // Window read data.
  output wire        o_win_rvalid,            // Window read data valid pulse.
  input  wire [7:0]  i_cfg_addr,              // Configuration register offset.
  input  wire        i_cfg_wr,                // Configuration write strobe.
  input  wire        i_cfg_rd,                // Configuration read strobe.
  input  wire [1:0]  i_cfg_be,                // Configuration byte enables.
  input  wire [15:0] i_cfg_wdata,             // Configuration write data.
  output wire [15:0] o_cfg_rdata,             // Configuration read data.
  output wire        o_cfg_rvalid,            // Configuration read data valid pulse.
  input  wire        i_clock_run_en,          // Clock run owns terminal 0.
  input  wire        i_clock_run_out,         // Clock run output level.
  input  wire        i_clock_run_oe_n,        // Clock run enable, low drives.
  input  wire        i_power_override_en,     // Power override owns terminal 1.
  input  wire        i_power_override_out,    // Power override output level.
  input  wire        i_power_override_oe_n,   // Power override enable, low drives.
  input  wire        i_serial_clk_en,         // Serial clock owns terminal 4.
  input  wire        i_serial_clk_out,        // Serial clock output level.
  input  wire        i_serial_clk_oe_n,       // Serial clock enable, low drives.
  input  wire        i_serial_data_en,        // Serial data owns terminal 5.
  input  wire        i_serial_data_out,       // Serial data output level.
  input  wire        i_serial_data_oe_n,      // Serial data enable, low drives.
  input  wire [7:0]  i_pin,                   // Pad levels in.
  output wire [7:0]  o_pin,                   // Pad levels out.
  output wire [7:0]  o_pin_oe_n               // Pad enables, low while driving.
);

  // ========================================================================
  // Register selection from an offset pair; used by both access paths.
  function [1:0] gp8_decode;
    input [7:0] addr;
    input [7:0] dir_off;
    input [7:0] lvl_off;
    begin
      gp8_decode                = 2'h0;
      gp8_decode[`GP8_SEL_DIR]  = (addr == dir_off);
      gp8_decode[`GP8_SEL_LVL]  = (addr == lvl_off);
    end
  endfunction

  // ========================================================================
  // Read data for a selection; unmapped offsets read as zero.
  function [15:0] gp8_rd_mux;
    input [1:0] sel;
    input [7:0] dir_val;
    input [7:0] lvl_val;
    begin
      if (sel[`GP8_SEL_DIR]) begin
        gp8_rd_mux = {`GP8_RSVD_HI, dir_val};
      end else if (sel[`GP8_SEL_LVL]) begin
        gp8_rd_mux = {`GP8_RSVD_HI, lvl_val};
      end else begin
        gp8_rd_mux = `GP8_RDATA_RST;
      end
    end
  endfunction

  // ========================================================================
  // Declarations.
  reg  [7:0]  dir_ff;
  reg  [7:0]  nxt_dir_ff;
  reg  [7:0]  out_ff;
  reg  [7:0]  nxt_out_ff;
  reg  [7:0]  pin_in_ff;
  reg  [15:0] win_rdata_ff;
  reg  [15:0] cfg_rdata_ff;
  reg         win_rvalid_ff;
  reg         cfg_rvalid_ff;
  reg  [7:0]  sec_en;
  reg  [7:0]  sec_out;
  reg  [7:0]  sec_oe_n;
  wire [1:0]  win_sel;
  wire [1:0]  cfg_sel;
  wire        soft_clr;
  wire        win_dir_we;
  wire        win_lvl_we;
  wire        cfg_dir_we;
  wire        cfg_lvl_we;
  wire [7:0]  writable;
  wire [7:0]  lvl_src;
  wire [7:0]  read_val;

  // ========================================================================
  // Secondary function ownership; unshared terminals stay general purpose.
  always @* begin
    sec_en                    = 8'h00;
    sec_out                   = 8'h00;
    sec_oe_n                  = 8'hff;
    sec_en[`GP8_CLKRUN_BIT]   = i_clock_run_en;
    sec_out[`GP8_CLKRUN_BIT]  = i_clock_run_out;
    sec_oe_n[`GP8_CLKRUN_BIT] = i_clock_run_oe_n;
    sec_en[`GP8_PWROVR_BIT]   = i_power_override_en;
    sec_out[`GP8_PWROVR_BIT]  = i_power_override_out;
    sec_oe_n[`GP8_PWROVR_BIT] = i_power_override_oe_n;
    sec_en[`GP8_SCLK_BIT]     = i_serial_clk_en;
    sec_out[`GP8_SCLK_BIT]    = i_serial_clk_out;
    sec_oe_n[`GP8_SCLK_BIT]   = i_serial_clk_oe_n;
    sec_en[`GP8_SDATA_BIT]    = i_serial_data_en;
    sec_out[`GP8_SDATA_BIT]   = i_serial_data_out;
    sec_oe_n[`GP8_SDATA_BIT]  = i_serial_data_oe_n;
    sec_en                    = sec_en & `GP8_SEC_MASK;
  end

  // ========================================================================
  // Address decode for the window and configuration paths.
  assign win_sel    = gp8_decode(i_win_addr, `GP8_WIN_DIR_OFF, `GP8_WIN_LVL_OFF);
  assign cfg_sel    = gp8_decode(i_cfg_addr, `GP8_CFG_DIR_OFF, `GP8_CFG_LVL_OFF);

  // Only the low byte holds storage, so the high byte enable is ignored.
  assign win_dir_we = i_win_wr & win_sel[`GP8_SEL_DIR] & i_win_be[`GP8_BE_LO];
  assign win_lvl_we = i_win_wr & win_sel[`GP8_SEL_LVL] & i_win_be[`GP8_BE_LO];
  assign cfg_dir_we = i_cfg_wr & cfg_sel[`GP8_SEL_DIR] & i_cfg_be[`GP8_BE_LO];
  assign cfg_lvl_we = i_cfg_wr & cfg_sel[`GP8_SEL_LVL] & i_cfg_be[`GP8_BE_LO];

  assign soft_clr   = ~i_link_fund_rst_n | ~i_global_reset_input_n;

  // ========================================================================
  // Direction register; a window write wins over a simultaneous alias write.
  always @* begin
    nxt_dir_ff = dir_ff;
    if (soft_clr) begin
      nxt_dir_ff = `GP8_DIR_RST;
    end else if (win_dir_we) begin
      nxt_dir_ff = i_win_wdata[`GP8_LO_MSB:`GP8_LO_LSB];
    end else if (cfg_dir_we) begin
      nxt_dir_ff = i_cfg_wdata[`GP8_LO_MSB:`GP8_LO_LSB];
    end
  end

  // ========================================================================
  // Data register; only output-mode terminals without a secondary owner
  // accept a written bit, judged on the direction held before the write.
  assign writable = dir_ff & ~sec_en;
  assign lvl_src  = win_lvl_we ? i_win_wdata[`GP8_LO_MSB:`GP8_LO_LSB] :
                                 i_cfg_wdata[`GP8_LO_MSB:`GP8_LO_LSB];

  always @* begin
    nxt_out_ff = out_ff;
    if (soft_clr) begin
      nxt_out_ff = `GP8_LVL_RST;
    end else if (win_lvl_we | cfg_lvl_we) begin
      nxt_out_ff = (lvl_src & writable) | (out_ff & ~writable);
    end
  end

  // ========================================================================
  // Storage and pad sampling.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dir_ff    <= `GP8_DIR_RST;
      out_ff    <= `GP8_LVL_RST;
      pin_in_ff <= `GP8_LVL_RST;
    end else begin
      dir_ff    <= nxt_dir_ff;
      out_ff    <= nxt_out_ff;
      pin_in_ff <= i_pin;
    end
  end

  // ========================================================================
  // Per-terminal pad and read-back logic.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      gp8_pin_cell u_cell (
        .i_dir        (dir_ff[g]),
        .i_sec_en     (sec_en[g]),
        .i_out_val    (out_ff[g]),
        .i_sec_out    (sec_out[g]),
        .i_sec_oe_n   (sec_oe_n[g]),
        .i_pin_sample (pin_in_ff[g]),
        .o_pin        (o_pin[g]),
        .o_pin_oe_n   (o_pin_oe_n[g]),
        .o_read_val   (read_val[g])
      );
    end
  endgenerate

  // ========================================================================
  // Read answers, one cycle after the strobe on each path.
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      win_rdata_ff  <= `GP8_RDATA_RST;
      cfg_rdata_ff  <= `GP8_RDATA_RST;
      win_rvalid_ff <= 1'b0;
      cfg_rvalid_ff <= 1'b0;
    end else begin
      win_rvalid_ff <= i_win_rd;
      cfg_rvalid_ff <= i_cfg_rd;
      if (i_win_rd) begin
        win_rdata_ff <= gp8_rd_mux(win_sel, dir_ff, read_val);
      end
      if (i_cfg_rd) begin
        cfg_rdata_ff <= gp8_rd_mux(cfg_sel, dir_ff, read_val);
      end
    end
  end

  assign o_win_rdata  = win_rdata_ff;
  assign o_win_rvalid = win_rvalid_ff;
  assign o_cfg_rdata  = cfg_rdata_ff;
  assign o_cfg_rvalid = cfg_rvalid_ff;

endmodule

// ---- rtl/gp8_map.vh ----
`ifndef GP8_MAP_VH
`define GP8_MAP_VH

// ==========================================================================
// Register offsets in the device control memory window.
`define GP8_WIN_DIR_OFF   8'h40
`define GP8_WIN_LVL_OFF   8'h42

// ==========================================================================
// Register offsets in configuration space (aliases of the same storage).
`define GP8_CFG_DIR_OFF   8'hb4
`define GP8_CFG_LVL_OFF   8'hb6

// ==========================================================================
// Reset values and reserved fields.
`define GP8_DIR_RST       8'h00
`define GP8_LVL_RST       8'h00
`define GP8_RSVD_HI       8'h00
`define GP8_RDATA_RST     16'h0000

// ==========================================================================
// Field positions.
`define GP8_LO_MSB        7
`define GP8_LO_LSB        0
`define GP8_BE_LO         0
`define GP8_SEL_DIR       0
`define GP8_SEL_LVL       1

// ==========================================================================
// Terminals shared with secondary functions.
`define GP8_CLKRUN_BIT    0
`define GP8_PWROVR_BIT    1
`define GP8_SCLK_BIT      4
`define GP8_SDATA_BIT     5
`define GP8_SEC_MASK      8'h33

`endif

// ---- rtl/gp8_pin_cell.v ----
`timescale 1ns/1ps

// ==========================================================================
// One terminal: chooses who drives the pad and what a data read returns.
module gp8_pin_cell (
  input  wire i_dir,         // Direction bit, 1 selects output mode.
  input  wire i_sec_en,      // Secondary function owns this terminal.
  input  wire i_out_val,     // Stored output level.
  input  wire i_sec_out,     // Level from the secondary function.
  input  wire i_sec_oe_n,    // Enable from the secondary function, low drives.
  input  wire i_pin_sample,  // Sampled pad level.
  output wire o_pin,         // Level towards the pad.
  output wire o_pin_oe_n,    // Pad enable, low while driving.
  output wire o_read_val     // Value returned by a data read.
);

  wire gp_drive;

  // The direction bit counts only while no secondary function owns the pin.
  assign gp_drive   = i_dir & ~i_sec_en;
  assign o_pin      = i_sec_en ? i_sec_out : i_out_val;
  assign o_pin_oe_n = i_sec_en ? i_sec_oe_n : ~gp_drive;
  // Output mode without a secondary owner reads back the stored level, otherwise the pad.
  assign o_read_val = gp_drive ? i_out_val : i_pin_sample;

endmodule

// ---- dv/gp8_port_sva.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Port-level checks for the eight-pin port.
module gp8_port_sva (
  input wire        i_core_clk, i_resetn, i_link_fund_rst_n, i_global_reset_input_n,
  input wire [7:0]  i_win_addr,
  input wire        i_win_wr, i_win_rd,
  input wire [1:0]  i_win_be,
  input wire [15:0] i_win_wdata, o_win_rdata,
  input wire        o_win_rvalid,
  input wire        i_clock_run_en, i_clock_run_out, i_clock_run_oe_n,
  input wire        i_power_override_en, i_power_override_out, i_power_override_oe_n,
  input wire        i_serial_clk_en, i_serial_clk_out, i_serial_clk_oe_n,
  input wire        i_serial_data_en, i_serial_data_out, i_serial_data_oe_n,
  input wire [7:0]  o_pin, o_pin_oe_n
);
  wire [7:0] sec = {2'b00, i_serial_data_en, i_serial_clk_en, 2'b00, i_power_override_en, i_clock_run_en};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_dir_wr;
    i_win_wr && i_win_addr == 8'h40 && i_win_be[0] && i_link_fund_rst_n && i_global_reset_input_n;
  endsequence
  sequence s_rd_answer;
    o_win_rvalid && o_win_rdata[15:8] == 8'h00;
  endsequence
  property p_dir_wr;
    s_dir_wr |=> ((o_pin_oe_n | sec) == (~$past(i_win_wdata[7:0]) | sec));
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("pad enables differ from direction written");
  property p_rd_hi;
    i_win_rd |=> s_rd_answer;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("read answer missing or upper byte set");
  property p_sec0;
    i_clock_run_en |-> o_pin_oe_n[0] == i_clock_run_oe_n && o_pin[0] == i_clock_run_out;
  endproperty
  a_sec0: assert property (p_sec0) else $error("terminal 0 not owned by clock run");
  property p_sec1;
    i_power_override_en |-> o_pin_oe_n[1] == i_power_override_oe_n && o_pin[1] == i_power_override_out;
  endproperty
  a_sec1: assert property (p_sec1) else $error("terminal 1 not owned by power override");
  property p_sec4;
    i_serial_clk_en |-> o_pin_oe_n[4] == i_serial_clk_oe_n && o_pin[4] == i_serial_clk_out;
  endproperty
  a_sec4: assert property (p_sec4) else $error("terminal 4 not owned by serial clock");
  property p_sec5;
    i_serial_data_en |-> o_pin_oe_n[5] == i_serial_data_oe_n && o_pin[5] == i_serial_data_out;
  endproperty
  a_sec5: assert property (p_sec5) else $error("terminal 5 not owned by serial data");
  property p_link_rst;
    !i_link_fund_rst_n |=> (o_pin_oe_n | sec) == 8'hff;
  endproperty
  a_link_rst: assert property (p_link_rst) else $error("link reset left a pad driven");
  property p_glb_rst;
    $fell(i_global_reset_input_n) |=> (o_pin_oe_n | sec) == 8'hff && (o_pin & ~sec) == 8'h00;
  endproperty
  a_glb_rst: assert property (p_glb_rst) else $error("global reset left a pad driven");
endmodule

bind gp8_port gp8_port_sva sva (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_link_fund_rst_n(i_link_fund_rst_n), .i_global_reset_input_n(i_global_reset_input_n),
  .i_win_addr(i_win_addr), .i_win_wr(i_win_wr), .i_win_rd(i_win_rd), .i_win_be(i_win_be),
  .i_win_wdata(i_win_wdata), .o_win_rdata(o_win_rdata), .o_win_rvalid(o_win_rvalid),
  .i_clock_run_en(i_clock_run_en), .i_clock_run_out(i_clock_run_out), .i_clock_run_oe_n(i_clock_run_oe_n),
  .i_power_override_en(i_power_override_en), .i_power_override_out(i_power_override_out),
  .i_power_override_oe_n(i_power_override_oe_n), .i_serial_clk_en(i_serial_clk_en),
  .i_serial_clk_out(i_serial_clk_out), .i_serial_clk_oe_n(i_serial_clk_oe_n),
  .i_serial_data_en(i_serial_data_en), .i_serial_data_out(i_serial_data_out),
  .i_serial_data_oe_n(i_serial_data_oe_n), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n));

// ---- dv/gp8_board.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Board side: drives each pad that the port leaves released.
module gp8_board (
  input  wire [7:0] i_pin_out,   // Port output levels.
  input  wire [7:0] i_pin_oe_n,  // Port enables, low while driving.
  input  wire [7:0] i_ext,       // Board levels on released pads.
  output wire [7:0] o_pad        // Resolved pad levels.
);
  assign o_pad = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & i_ext);
endmodule

// ---- dv/tb_gp8_port.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Register and pad tests for the eight-pin port.
module tb_gp8_port;
  logic        clk = 1'b0, rst_n = 1'b0, lrst_n = 1'b1, global_reset_input_n = 1'b1;
  logic [7:0]  w_addr = 8'h00, c_addr = 8'h00, ext = 8'ha5;
  logic        w_wr = 1'b0, w_rd = 1'b0, c_wr = 1'b0, c_rd = 1'b0;
  logic [1:0]  w_be = 2'b00, c_be = 2'b00;
  logic [15:0] w_wd = 16'h0000, c_wd = 16'h0000;
  logic [3:0]  s_en = 4'h0, s_out = 4'h5, s_oe_n = 4'hf;
  wire  [15:0] w_rdat, c_rdat;
  wire         w_rv, c_rv;
  wire  [7:0]  pin_in, pin_out, pin_oe_n;
  int          err_total = 0, compares = 0;
  always #12.5 clk = ~clk;
  gp8_port uut (.i_core_clk(clk), .i_resetn(rst_n), .i_link_fund_rst_n(lrst_n), .i_global_reset_input_n(global_reset_input_n),
    .i_win_addr(w_addr), .i_win_wr(w_wr), .i_win_rd(w_rd), .i_win_be(w_be), .i_win_wdata(w_wd),
    .o_win_rdata(w_rdat), .o_win_rvalid(w_rv), .i_cfg_addr(c_addr), .i_cfg_wr(c_wr), .i_cfg_rd(c_rd),
    .i_cfg_be(c_be), .i_cfg_wdata(c_wd), .o_cfg_rdata(c_rdat), .o_cfg_rvalid(c_rv),
    .i_clock_run_en(s_en[0]), .i_clock_run_out(s_out[0]), .i_clock_run_oe_n(s_oe_n[0]),
    .i_power_override_en(s_en[1]), .i_power_override_out(s_out[1]), .i_power_override_oe_n(s_oe_n[1]),
    .i_serial_clk_en(s_en[2]), .i_serial_clk_out(s_out[2]), .i_serial_clk_oe_n(s_oe_n[2]),
    .i_serial_data_en(s_en[3]), .i_serial_data_out(s_out[3]), .i_serial_data_oe_n(s_oe_n[3]),
    .i_pin(pin_in), .o_pin(pin_out), .o_pin_oe_n(pin_oe_n));
  gp8_board board (.i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .i_ext(ext), .o_pad(pin_in));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One access; for a read, d is the expected read data.
  task acc(input bit cfg, input bit wr, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk);
    if (cfg) begin
      c_addr = a;
      c_be = be;
      c_wd = d;
      c_wr = wr;
      c_rd = !wr;
    end else begin
      w_addr = a;
      w_be = be;
      w_wd = d;
      w_wr = wr;
      w_rd = !wr;
    end
    @(negedge clk);
    c_wr = 1'b0;
    c_rd = 1'b0;
    w_wr = 1'b0;
    w_rd = 1'b0;
    if (!wr) begin
      chk({15'h0000, cfg ? c_rv : w_rv}, 16'h0001);
      chk(cfg ? c_rdat : w_rdat, d);
    end
  endtask
  task complete_run;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #75000;
    err_total++;
    complete_run;
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    acc(0, 0, 8'h40, 2'b00, 16'h0000);
    chk({8'h00, pin_oe_n}, 16'h00ff);
    acc(0, 0, 8'h42, 2'b00, 16'h00a5);
    $display("test 1 done");
    acc(0, 1, 8'h40, 2'b01, 16'hff0f);
    acc(1, 0, 8'hb4, 2'b00, 16'h000f);
    acc(0, 1, 8'h42, 2'b01, 16'hff5a);
    acc(0, 1, 8'h42, 2'b00, 16'h0005);
    acc(0, 0, 8'h42, 2'b00, 16'h00aa);
    acc(1, 0, 8'hb6, 2'b00, 16'h00aa);
    chk({pin_oe_n, pin_out & 8'h0f}, 16'hf00a);
    $display("test 2 done");
    acc(1, 1, 8'hb4, 2'b01, 16'h00ff);
    s_en = 4'hf;
    acc(0, 1, 8'h42, 2'b01, 16'h00ff);
    acc(0, 0, 8'h42, 2'b00, 16'h00ed);
    chk({8'h00, pin_oe_n}, 16'h0033);
    s_oe_n = 4'h0;
    acc(0, 0, 8'h40, 2'b00, 16'h00ff);
    s_en = 4'h0;
    acc(0, 0, 8'h42, 2'b00, 16'h00ce);
    chk({8'h00, pin_out}, 16'h00ce);
    // Data written through the configuration alias, then an offset unmapped on that path.
    acc(1, 1, 8'hb6, 2'b01, 16'h0011);
    acc(0, 0, 8'h42, 2'b00, 16'h0011);
    acc(1, 0, 8'h42, 2'b00, 16'h0000);
    $display("test 3 done");
    for (int k = 0; k < 3; k++) begin
      acc(0, 1, 8'h40, 2'b01, 16'h003c);
      if (k == 0) lrst_n = 1'b0;
      else if (k == 1) global_reset_input_n = 1'b0;
      else rst_n = 1'b0;
      @(negedge clk);
      lrst_n = 1'b1;
      global_reset_input_n = 1'b1;
      rst_n = 1'b1;
      acc(0, 0, 8'h40, 2'b00, 16'h0000);
      chk({8'h00, pin_oe_n}, 16'h00ff);
    end
    $display("test 4 done");
    complete_run;
  end
endmodule
